// File: rtl/fpnn_unit.sv
// fpnn_unit: fixed-point negate/nand slice with a general register file,
// exception and condition flags, reached as an ahb-lite slave
// assumes one 50 MHz clock, hreadyout wired back as the bus hready
//
// Functional notes
// - opcode 31/488 writes negative absolute value
// - nabs with overflow enable clears overflow
// - carry flag never changed by nabs/neg
// - record bit updates condition field zero
// - opcode 476: nand sources into first field
// - nand leaves exception flags untouched
// - opcode 104 writes two's-complement negation
// - most negative negates to itself, overflows
// - neg with overflow enable updates overflow, summary
// - bit 21 enables overflow; else flags kept
// - nabs legal only in legacy variant
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module fpnn_unit
  import fpnn_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  // register file and bus tracking
  logic [31:0] genreg_mem [0:31];
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic rd_wait_reg;
  logic [11:0] rd_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic irq_reg;
  // architected and status state
  logic legacy_reg;
  logic [31:0] instr_reg;
  logic xer_so_reg;
  logic xer_ovf_reg;
  logic xer_carry_reg;
  logic [3:0] cr0_reg;
  logic last_ill_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [31:0] opcnt_reg;
  logic [31:0] result_reg;
  // strobes, next values and datapath results
  logic addr_ok;
  logic wr_strobe;
  logic issue;
  logic [2:0] irq_event;
  logic [2:0] irq_stat_next;
  logic [2:0] irq_mask_next;
  logic [31:0] rd_mux;
  logic alu_legal;
  logic [4:0] alu_dest;
  logic [31:0] alu_result;
  logic alu_ovf_we;
  logic alu_ovf_val;
  logic alu_so_next;
  logic alu_cr_we;
  logic [3:0] alu_cr0;

  // register window decode shared by reads and writes
  function automatic logic is_genreg(input logic [11:0] a);
    return (a & FPNN_GENREG_MASK) == FPNN_OFF_GENREG_BASE;
  endfunction

  // software write landing on one register this cycle
  function automatic logic wr_hit(input logic stb, input logic [11:0] a,
    input logic [11:0] off);
    return stb && (a == off);
  endfunction

  // ****************************************************************
  // ahb-lite address phase and data phase tracking
  // ****************************************************************
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_strobe = wr_pend_reg;
  assign issue = wr_hit(wr_strobe, wr_addr_reg, FPNN_OFF_INSTR);

  // capture write address phase, data applied one cycle later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end
    else if (clk_en)
    begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok && hwrite)
        wr_addr_reg <= haddr[11:0];
    end
  end

  // reads insert one wait state so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_wait_reg <= 1'b0;
      rd_addr_reg <= 12'h000;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0;
    end
    else if (clk_en)
    begin
      if (addr_ok && !hwrite)
      begin
        rd_wait_reg <= 1'b1;
        rd_addr_reg <= haddr[11:0];
        hreadyout_reg <= 1'b0;
      end
      else if (rd_wait_reg)
      begin
        rd_wait_reg <= 1'b0;
        hreadyout_reg <= 1'b1;
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // read multiplexer, unmapped offsets read zero
  // ****************************************************************
  always_comb
  begin
    rd_mux = 32'h0;
    if (is_genreg(rd_addr_reg))
      rd_mux = genreg_mem[rd_addr_reg[6:2]];
    else
    begin
      case (rd_addr_reg)
        FPNN_OFF_CTRL: rd_mux[FPNN_CTRL_LEGACY] = legacy_reg;
        FPNN_OFF_INSTR: rd_mux = instr_reg;
        FPNN_OFF_XER:
        begin
          rd_mux[FPNN_XER_SO] = xer_so_reg;
          rd_mux[FPNN_XER_OVF] = xer_ovf_reg;
          rd_mux[FPNN_XER_CARRY] = xer_carry_reg;
        end
        FPNN_OFF_CR: rd_mux[3:0] = cr0_reg;
        FPNN_OFF_STAT: rd_mux[0] = last_ill_reg;
        FPNN_OFF_IRQ_STAT: rd_mux[2:0] = irq_stat_reg;
        FPNN_OFF_IRQ_MASK: rd_mux[2:0] = irq_mask_reg;
        FPNN_OFF_OPCNT: rd_mux = opcnt_reg;
        FPNN_OFF_RESULT: rd_mux = result_reg;
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // execution datapath, fed straight from the written instruction
  // ****************************************************************
  // operands picked by the fields of the word now on the write data
  fpnn_alu u_alu (
    .instr(hwdata),
    .first_val(genreg_mem[hwdata[FPNN_FIRST_LSB +: 5]]),
    .source_val(genreg_mem[hwdata[FPNN_TGT_LSB +: 5]]),
    .second_val(genreg_mem[hwdata[FPNN_SECOND_LSB +: 5]]),
    .so_in(xer_so_reg),
    .legacy_en(legacy_reg),
    .legal(alu_legal),
    .dest_idx(alu_dest),
    .result(alu_result),
    .ovf_we(alu_ovf_we),
    .ovf_val(alu_ovf_val),
    .so_next(alu_so_next),
    .cr_we(alu_cr_we),
    .cr0_val(alu_cr0)
  );

  // ****************************************************************
  // general register file, software write or result write-back
  // ****************************************************************
  always_ff @(posedge hclk)
  begin
    if (clk_en)
    begin
      // result write-back takes precedence over a software write
      if (issue && alu_legal)
        genreg_mem[alu_dest] <= alu_result;
      else if (wr_strobe && is_genreg(wr_addr_reg))
        genreg_mem[wr_addr_reg[6:2]] <= hwdata;
    end
  end

  // ****************************************************************
  // control and issue registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      legacy_reg <= FPNN_CTRL_RST;
      instr_reg <= 32'h0;
      last_ill_reg <= 1'b0;
      opcnt_reg <= 32'h0;
      result_reg <= 32'h0;
    end
    else if (clk_en)
    begin
      if (wr_hit(wr_strobe, wr_addr_reg, FPNN_OFF_CTRL))
        legacy_reg <= hwdata[FPNN_CTRL_LEGACY];
      // word kept for read-back; count and result only for legal words
      if (issue)
      begin
        instr_reg <= hwdata;
        last_ill_reg <= !alu_legal;
        if (alu_legal)
        begin
          opcnt_reg <= 32'(opcnt_reg + 32'h1);
          result_reg <= alu_result;
        end
      end
    end
  end

  // ****************************************************************
  // exception register flags
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      xer_so_reg <= FPNN_XER_RST[2];
      xer_ovf_reg <= FPNN_XER_RST[1];
      xer_carry_reg <= FPNN_XER_RST[0];
    end
    else if (clk_en)
    begin
      if (wr_hit(wr_strobe, wr_addr_reg, FPNN_OFF_XER))
      begin
        xer_so_reg <= hwdata[FPNN_XER_SO];
        xer_ovf_reg <= hwdata[FPNN_XER_OVF];
        xer_carry_reg <= hwdata[FPNN_XER_CARRY];
      end
      // software write and issue never share a cycle
      else if (issue && alu_legal && alu_ovf_we)
      begin
        xer_ovf_reg <= alu_ovf_val;
        xer_so_reg <= alu_so_next;
      end
      // carry is only ever written by software here
    end
  end

  // ****************************************************************
  // condition field zero
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cr0_reg <= FPNN_CR_RST;
    else if (clk_en)
    begin
      if (wr_hit(wr_strobe, wr_addr_reg, FPNN_OFF_CR))
        cr0_reg <= hwdata[3:0];
      else if (issue && alu_cr_we)
        cr0_reg <= alu_cr0;
    end
  end

  // ****************************************************************
  // interrupt status, mask and output
  // ****************************************************************
  always_comb
  begin
    irq_event = 3'h0;
    irq_event[FPNN_IRQ_DONE] = issue && alu_legal;
    irq_event[FPNN_IRQ_OVF] = issue && alu_legal && alu_ovf_we && alu_ovf_val;
    irq_event[FPNN_IRQ_ILL] = issue && !alu_legal;
    irq_stat_next = irq_stat_reg;
    if (wr_hit(wr_strobe, wr_addr_reg, FPNN_OFF_IRQ_STAT))
      irq_stat_next = irq_stat_reg & ~hwdata[2:0];
    // a new event wins over a clear in the same cycle
    irq_stat_next = irq_stat_next | irq_event;
    // mask as it stands after this edge, so irq follows a mask write at once
    irq_mask_next = irq_mask_reg;
    if (wr_hit(wr_strobe, wr_addr_reg, FPNN_OFF_IRQ_MASK))
      irq_mask_next = hwdata[2:0];
  end

  // sticky status and mask registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_stat_reg <= FPNN_IRQ_RST;
      irq_mask_reg <= FPNN_IRQ_RST;
    end
    else if (clk_en)
    begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // registered level interrupt from next status and mask values
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_reg <= 1'b0;
    else if (clk_en)
      irq_reg <= |(irq_stat_next & irq_mask_next);
  end

  // response is always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else if (clk_en)
      hresp <= 1'b0;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // every port below comes straight from a flop
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign irq = irq_reg;

endmodule // fpnn_unit

// File: shared/fpnn_pkg.sv
// fpnn_pkg: constants, types and helpers of the fixed-point negate/nand unit
// assumes a 32-bit instruction word with bit 0 of the printed layout as the msb
package fpnn_pkg;

  // ****************************************************************
  // register offsets, byte addresses on the 12-bit decoded window
  // ****************************************************************
  localparam logic [11:0] FPNN_OFF_CTRL = 12'h000;
  localparam logic [11:0] FPNN_OFF_INSTR = 12'h004;
  localparam logic [11:0] FPNN_OFF_XER = 12'h008;
  localparam logic [11:0] FPNN_OFF_CR = 12'h00c;
  localparam logic [11:0] FPNN_OFF_STAT = 12'h010;
  localparam logic [11:0] FPNN_OFF_IRQ_STAT = 12'h014;
  localparam logic [11:0] FPNN_OFF_IRQ_MASK = 12'h018;
  localparam logic [11:0] FPNN_OFF_OPCNT = 12'h01c;
  localparam logic [11:0] FPNN_OFF_RESULT = 12'h020;
  localparam logic [11:0] FPNN_OFF_GENREG_BASE = 12'h080;
  localparam logic [11:0] FPNN_GENREG_MASK = 12'hf80;

  // ****************************************************************
  // instruction fields, lsb positions in the 32-bit word
  // ****************************************************************
  localparam int FPNN_PRIM_LSB = 26;
  localparam int FPNN_TGT_LSB = 21;
  localparam int FPNN_FIRST_LSB = 16;
  localparam int FPNN_SECOND_LSB = 11;
  localparam int FPNN_OE_BIT = 10;
  localparam int FPNN_XO9_LSB = 1;
  localparam int FPNN_XO10_LSB = 1;
  localparam int FPNN_REC_BIT = 0;
  localparam logic [5:0] FPNN_PRIMARY = 6'h1f;
  localparam logic [8:0] FPNN_XO_NABS = 9'h1e8;
  localparam logic [8:0] FPNN_XO_NEG = 9'h068;
  localparam logic [9:0] FPNN_XO_NAND = 10'h1dc;

  // ****************************************************************
  // flag positions and reset values
  // ****************************************************************
  localparam int FPNN_XER_SO = 31;
  localparam int FPNN_XER_OVF = 30;
  localparam int FPNN_XER_CARRY = 29;
  localparam int FPNN_CR_NEG = 3;
  localparam int FPNN_CR_POS = 2;
  localparam int FPNN_CR_ZERO = 1;
  localparam int FPNN_CR_SO = 0;
  localparam int FPNN_CTRL_LEGACY = 0;
  localparam int FPNN_IRQ_DONE = 0;
  localparam int FPNN_IRQ_OVF = 1;
  localparam int FPNN_IRQ_ILL = 2;
  localparam logic FPNN_CTRL_RST = 1'b1;
  localparam logic [2:0] FPNN_XER_RST = 3'h0;
  localparam logic [3:0] FPNN_CR_RST = 4'h0;
  localparam logic [2:0] FPNN_IRQ_RST = 3'h0;
  localparam logic [31:0] FPNN_MIN_NEG = 32'h8000_0000;

  typedef enum logic [1:0] {FPNN_OP_NONE, FPNN_OP_NABS, FPNN_OP_NAND, FPNN_OP_NEG} fpnn_op_t;

  // operation from primary and extended opcode fields
  function automatic fpnn_op_t fpnn_decode(input logic [31:0] instr);
    fpnn_op_t op;
    op = FPNN_OP_NONE;
    if (instr[FPNN_PRIM_LSB +: 6] == FPNN_PRIMARY)
    begin
      if (instr[FPNN_XO9_LSB +: 9] == FPNN_XO_NABS)
        op = FPNN_OP_NABS;
      else if (instr[FPNN_XO9_LSB +: 9] == FPNN_XO_NEG)
        op = FPNN_OP_NEG;
      else if (instr[FPNN_XO10_LSB +: 10] == FPNN_XO_NAND)
        op = FPNN_OP_NAND;
    end
    return op;
  endfunction

  // condition field zero from a signed compare with zero
  function automatic logic [3:0] fpnn_cr0(input logic [31:0] res, input logic so);
    logic [3:0] cr;
    cr = 4'h0;
    cr[FPNN_CR_NEG] = res[31];
    cr[FPNN_CR_POS] = !res[31] && (res != 32'h0);
    cr[FPNN_CR_ZERO] = (res == 32'h0);
    cr[FPNN_CR_SO] = so;
    return cr;
  endfunction

endpackage

// File: rtl/fpnn_alu.sv
// fpnn_alu: combinational datapath for negative absolute, nand and negate
// assumes operands already read from the general registers by the caller
`timescale 1ns/1ns
module fpnn_alu
  import fpnn_pkg::*;
(
  input wire logic [31:0] instr,
  input wire logic [31:0] first_val,
  input wire logic [31:0] source_val,
  input wire logic [31:0] second_val,
  input wire logic so_in,
  input wire logic legacy_en,
  output logic legal,
  output logic [4:0] dest_idx,
  output logic [31:0] result,
  output logic ovf_we,
  output logic ovf_val,
  output logic so_next,
  output logic cr_we,
  output logic [3:0] cr0_val
);

  fpnn_op_t op;
  logic oe;

  // ****************************************************************
  // operation select and flag effects
  // ****************************************************************
  always_comb
  begin
    op = fpnn_decode(instr);
    oe = instr[FPNN_OE_BIT];
    legal = 1'b0;
    dest_idx = instr[FPNN_TGT_LSB +: 5];
    result = 32'h0;
    ovf_we = 1'b0;
    ovf_val = 1'b0;
    case (op)
      FPNN_OP_NABS:
      begin
        legal = legacy_en;
        result = first_val[31] ? first_val : 32'(~first_val + 32'h1);
        ovf_we = oe;
        ovf_val = 1'b0;
      end
      FPNN_OP_NAND:
      begin
        legal = 1'b1;
        dest_idx = instr[FPNN_FIRST_LSB +: 5];
        result = ~(source_val & second_val);
        ovf_we = 1'b0;
      end
      FPNN_OP_NEG:
      begin
        legal = 1'b1;
        result = 32'(~first_val + 32'h1);
        ovf_we = oe;
        ovf_val = (first_val == FPNN_MIN_NEG);
      end
      default:
      begin
        legal = 1'b0;
      end
    endcase
    // summary overflow only ever sets
    so_next = so_in | (legal && ovf_we && ovf_val);
    cr_we = legal && instr[FPNN_REC_BIT];
    cr0_val = fpnn_cr0(result, so_next);
  end

endmodule // fpnn_alu

// File: verification/fpnn_unit_props.sv
// fpnn_unit_props: bus timing and flag assertions on the unit's ports
// assumes hready is wired to hreadyout by the surrounding bench
`timescale 1ns/1ns
module fpnn_unit_props
  import fpnn_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq
);
  logic ph_reg;
  logic wr_reg;
  logic [11:0] ad_reg;
  logic carry_reg;
  logic so_reg;
  logic take;
  logic done;
  logic xer_rd;
  // address taken, data phase completed, exception word read back
  assign take = hsel && htrans[1] && hready && clk_en;
  assign done = ph_reg && hready && clk_en;
  assign xer_rd = done && !wr_reg && (ad_reg == FPNN_OFF_XER);
  // bus phase follower
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_reg <= 1'b0;
      wr_reg <= 1'b0;
      ad_reg <= 12'h000;
    end
    else if (hready && clk_en)
    begin
      ph_reg <= take;
      wr_reg <= hwrite;
      ad_reg <= haddr[11:0];
    end
  end
  // shadow of software-written flags; summary latches once seen set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      carry_reg <= 1'b0;
      so_reg <= 1'b0;
    end
    else if (done && wr_reg && (ad_reg == FPNN_OFF_XER))
    begin
      carry_reg <= hwdata[FPNN_XER_CARRY];
      so_reg <= hwdata[FPNN_XER_SO];
    end
    else if (xer_rd && hrdata[FPNN_XER_SO])
      so_reg <= 1'b1;
  end
  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout)
    else $error("read without wait state");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_one_a: assert property (!hreadyout && clk_en |=> hreadyout)
    else $error("wait longer than one cycle");
  rdata_hold_a: assert property (hreadyout |=> $stable(hrdata))
    else $error("read data moved outside a read");
  irq_cause_a: assert property ($rose(irq) |-> $past(done && wr_reg))
    else $error("interrupt rose without a write");
  carry_kept_a: assert property (xer_rd |-> hrdata[FPNN_XER_CARRY] == carry_reg)
    else $error("carry changed by execution");
  so_sticky_a: assert property (xer_rd && so_reg |-> hrdata[FPNN_XER_SO])
    else $error("summary overflow cleared");
endmodule // fpnn_unit_props

bind fpnn_unit fpnn_unit_props u_props (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .irq(irq));

// File: verification/fpnn_issue_model.sv
// fpnn_issue_model: issue side of the unit, a single-word ahb-lite master
// assumes hready comes from the unit's hreadyout on the same clock
`timescale 1ns/1ns
module fpnn_issue_model
  import fpnn_pkg::*;
(
  input wire logic hclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // idle bus at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one word; upper address bits are noise, released lines inverted
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'($urandom()), a};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      haddr <= ~haddr;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
    end
  endtask
endmodule // fpnn_issue_model

// File: verification/fpnn_unit_bench.sv
// fpnn_unit_bench: self-checking bench with a reference model of the unit
// assumes the issue model drives the bus and the property checker is bound
`timescale 1ns/1ns
module fpnn_unit_bench
  import fpnn_pkg::*;
;
  logic hclk;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q, m_res;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int m_cnt;
  logic [31:0] m_genreg[32];
  logic [2:0] m_xer, m_st, m_mask;
  logic [3:0] m_cr;
  logic m_leg, m_ill;
  int xo_q[$] = '{488, 104, 476};
  logic [31:0] val_q[$] = '{32'h0, 32'h1, 32'h8000_0000, 32'h7fff_ffff, 32'hffff_ffff};
  assign hready = hreadyout;
  fpnn_unit u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  fpnn_issue_model u_issue (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  // 50 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      end_sim();
    end
  end
  task automatic end_sim();
    begin
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        bad_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_issue.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    begin
      u_issue.xfer(1'b0, a, 32'h0, q);
      cmp(q, e);
    end
  endtask
  task automatic wrg(input logic [4:0] g, input logic [31:0] d);
    begin
      m_genreg[g] = d;
      wr(FPNN_OFF_GENREG_BASE + {5'h0, g, 2'b00}, d);
    end
  endtask
  // model one instruction word, then issue it
  task automatic issue(input logic [31:0] w);
    logic [31:0] s, r;
    logic [4:0] t, f;
    int op;
    begin
      t = w[25:21];
      f = w[20:16];
      s = m_genreg[f];
      op = (w[31:26] != 6'd31) ? 0 : (w[9:1] == 9'd488 && m_leg) ? 1 :
        (w[9:1] == 9'd104) ? 2 : (w[10:1] == 10'd476) ? 3 : 0;
      r = (op == 3) ? ~(m_genreg[t] & m_genreg[w[15:11]]) : (op == 2 || !s[31]) ? -s : s;
      m_ill = (op == 0);
      m_st[2] = m_st[2] | m_ill;
      if (op != 0)
      begin
        m_cnt++;
        m_res = r;
        m_st[0] = 1'b1;
        m_genreg[(op == 3) ? f : t] = r;
        if (w[10] && op == 2)
        begin
          m_xer[1] = (s == 32'h8000_0000);
          m_xer[2] = m_xer[2] | m_xer[1];
          m_st[1] = m_st[1] | m_xer[1];
        end
        if (w[10] && op == 1)
          m_xer[1] = 1'b0;
        if (w[0])
          m_cr = {r[31], !r[31] && (r != 32'h0), r == 32'h0, m_xer[2]};
      end
      wr(FPNN_OFF_INSTR, w);
    end
  endtask
  // read back everything an instruction may touch but the instruction word
  task automatic chk(input logic [4:0] t, input logic [4:0] f);
    begin
      rd_chk(FPNN_OFF_GENREG_BASE + {5'h0, t, 2'b00}, m_genreg[t]);
      rd_chk(FPNN_OFF_GENREG_BASE + {5'h0, f, 2'b00}, m_genreg[f]);
      rd_chk(FPNN_OFF_XER, {m_xer, 29'h0});
      rd_chk(FPNN_OFF_CR, {28'h0, m_cr});
      rd_chk(FPNN_OFF_RESULT, m_res);
      rd_chk(FPNN_OFF_OPCNT, m_cnt);
      rd_chk(FPNN_OFF_STAT, {31'h0, m_ill});
      rd_chk(FPNN_OFF_IRQ_STAT, {29'h0, m_st});
      cmp({31'h0, irq}, {31'h0, |(m_st & m_mask)});
    end
  endtask
  // reset, reset values, fresh registers, unmapped place
  task automatic start();
    begin
      hresetn <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      {m_xer, m_st, m_mask, m_cr, m_ill, m_res} = '0;
      m_leg = 1'b1;
      m_cnt = 0;
      rd_chk(FPNN_OFF_CTRL, 32'h1);
      rd_chk(FPNN_OFF_INSTR, 32'h0);
      rd_chk(FPNN_OFF_IRQ_MASK, 32'h0);
      for (int g = 0; g < 32; g++)
        wrg(g[4:0], $urandom());
      chk(5'd6, 5'd4);
      wr(12'h040, $urandom());
      rd_chk(12'h040, 32'h0);
      $display("reset test done");
    end
  endtask
  // main sequence
  initial
  begin
    logic [31:0] w;
    logic [31:0] d;
    w = $urandom(32'h3e87);
    start();
    wr(FPNN_OFF_IRQ_MASK, 32'h7);
    m_mask = 3'h7;
    for (int l = 1; l >= 0; l--)
    begin
      wr(FPNN_OFF_CTRL, l);
      m_leg = l[0];
      foreach (xo_q[k])
        for (int m = 0; m < 4; m++)
          foreach (val_q[j])
          begin
            d = $urandom() & 32'he000_0000;
            m_xer = d[31:29];
            wr(FPNN_OFF_XER, d);
            wrg(5'd4, val_q[j]);
            wrg(5'd6, val_q[j] ^ 32'h0f0f_0000);
            wrg(5'd7, $urandom());
            issue({6'd31, 5'd6, 5'd4, 5'd7, m[1], xo_q[k][8:0], m[0]});
            chk(5'd6, 5'd4);
          end
      $display("directed test done, variant %0d", l);
    end
    start();
    for (int i = 0; i < 60; i++)
    begin
      d = $urandom();
      m_mask = d[2:0];
      wr(FPNN_OFF_IRQ_MASK, {29'h0, d[2:0]});
      m_st = m_st & ~d[5:3];
      wr(FPNN_OFF_IRQ_STAT, {29'h0, d[5:3]});
      m_xer = d[31:29];
      wr(FPNN_OFF_XER, d & 32'he000_0000);
      m_leg = d[6];
      wr(FPNN_OFF_CTRL, {31'h0, d[6]});
      if (d[8:7] != 2'b00)
      begin
        clk_en <= 1'b0;
        repeat (d[8:7]) @(posedge hclk);
        clk_en <= 1'b1;
      end
      w = $urandom();
      if (d[10:9] != 2'b00)
        w[31:26] = 6'd31;
      if (d[12:11] != 2'b00)
        w[9:1] = xo_q[d[12:11] % 3][8:0];
      issue(w);
      chk(w[25:21], w[20:16]);
    end
    $display("random test done");
    end_sim();
  end
endmodule // fpnn_unit_bench
